// File: pkg/pccc_pkg.sv
// Constants shared by the classifier criterion configuration block
package pccc_pkg;
    // ========================================================
    // Register offsets (management register numbers)
    localparam logic [5:0] ADDR_UDP_DEST_PORT   = 6'h2A;
    localparam logic [5:0] ADDR_BIT_MASK        = 6'h2B;
    localparam logic [5:0] ADDR_BIT_PATTERN     = 6'h2C;
    localparam logic [5:0] ADDR_POSITION_ENABLE = 6'h2D;
    localparam logic [5:0] ADDR_COMMIT_CONTROL  = 6'h2E;
    // ========================================================
    // Reset values
    localparam logic [15:0] RST_UDP_DEST_PORT = 16'h013F;
    localparam logic [15:0] RST_BIT_MASK      = 16'h0000;
    localparam logic [15:0] RST_BIT_PATTERN   = 16'h0000;
    localparam logic [7:0]  RST_OFFSET        = 8'h00;
    localparam logic        RST_ENABLE        = 1'b0;
    localparam logic [3:0]  RST_SELECT        = 4'h0;
    localparam logic [7:0]  RST_HDR_POSITION  = 8'h00;
    // ========================================================
    // Field positions
    localparam int POS_ENABLE     = 15;
    localparam int POS_OFFSET_MSB = 7;
    localparam int POS_STROBE     = 7;
    localparam int POS_SEL_MSB    = 3;
    // ========================================================
    // Codes
    localparam logic [15:0] PORT_MATCH_OFF  = 16'hFFFF;
    localparam logic [3:0]  SEL_HDR_POS     = 4'hF;
    localparam logic [3:0]  SEL_LAST_CRIT   = 4'h7;
    localparam int          NUM_CRITERIA    = 8;
    // Criterion entry: {enable, offset[7:0], pattern[15:0], mask[15:0]}
    localparam int          ENTRY_W         = 41;

    typedef enum logic [1:0] {
        PCCC_IDLE   = 2'b00,
        PCCC_COMMIT = 2'b01
    } pccc_state_t;
endpackage : pccc_pkg

// File: design/pccc_crit_mem.sv
// Criterion store: small memory with registered read data
`timescale 1ns/1ps
module pccc_crit_mem #(
    parameter int DEPTH = 8,
    parameter int WIDTH = 41,
    parameter int AW    = 3
) (
    input  wire logic             core_clk_i,  // Core clock
    input  wire logic             resetn_i,    // Async reset, active low
    input  wire logic             wr_en_i,     // Write strobe
    input  wire logic [AW-1:0]    wr_addr_i,   // Write index
    input  wire logic [WIDTH-1:0] wr_data_i,   // Write word
    input  wire logic [AW-1:0]    rd_addr_i,   // Read index
    output logic      [WIDTH-1:0] rd_data_o    // Registered read word
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // ========================================================
    // Storage; reset so every criterion starts disabled
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < DEPTH; i++) mem_q[i] <= '0;
        end else if (wr_en_i) begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
    end

    // Read data from a register, one cycle after the address
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) rd_data_o <= '0;
        else rd_data_o <= mem_q[rd_addr_i];
    end
endmodule : pccc_crit_mem

// File: design/pccc_top.sv
// Classifier criterion configuration registers and criterion checks
// Notes on behaviour
// - IPv4 needs port equal when enabled
// - IPv6 needs port equal when enabled
// - All-ones port value disables port compare
// - Only mask-one bits are compared
// - Masked bits must equal pattern bits
// - Bit 15 is first packet bit
// - Enable sets criterion on/off, ignored for F
// - Byte offset from start locates compare point
// - Strobe copies staged set to selected target
// - Codes 0-7 select criteria 0-7
// - Code F loads offset into header position
// - Start field sets where offsets measure from
// - Combine bit: zero AND, one OR
`timescale 1ns/1ps
module pccc_top #(
    parameter int NCRIT = 8
) (
    input  wire logic        core_clk_i,        // 10 MHz core clock
    input  wire logic        resetn_i,          // Async reset, active low
    // Management register port
    input  wire logic [5:0]  reg_addr_i,        // Register number
    input  wire logic        reg_wr_i,          // Write strobe
    input  wire logic [15:0] reg_wdata_i,       // Write data
    output logic      [15:0] reg_rdata_o,       // Read data (comb)
    // Classifier controls held elsewhere
    input  wire logic        ipv4_timing_classify_en_i, // IPv4 class on
    input  wire logic        ipv6_timing_classify_en_i, // IPv6 class on
    input  wire logic [3:0]  start_select_i,    // Start position code
    input  wire logic        combine_or_i,      // 1 = OR, 0 = AND
    // Packet facts from the datapath
    input  wire logic        pkt_is_ipv4_i,     // Packet is IPv4/UDP
    input  wire logic        pkt_is_ipv6_i,     // Packet is IPv6/UDP
    input  wire logic [15:0] pkt_dest_port_i,   // UDP destination port
    output logic             port_ok_o,         // Port check passes
    // Criterion check stream
    input  wire logic        chk_valid_i,       // Check request
    input  wire logic        chk_first_i,       // First criterion of pkt
    input  wire logic        chk_last_i,        // Last criterion of pkt
    input  wire logic [2:0]  chk_idx_i,         // Criterion index
    input  wire logic [15:0] chk_word_i,        // Packet word, bit15 first
    input  wire logic        fixed_pass_i,      // Fixed classifier passed
    output logic [7:0]       crit_offset_o,     // Offset of checked crit
    output logic [3:0]       crit_start_o,      // Start code for that crit
    output logic             crit_hit_o,        // Checked crit result
    output logic             pkt_valid_o,       // Packet verdict valid
    output logic             pkt_pass_o,        // Packet verdict
    output logic [7:0]       timing_header_position_o // Header position
);
    // ========================================================
    // Staging registers
    logic [15:0] port_q, mask_q, pattern_q;
    logic [7:0]  offset_q, hdr_pos_q;
    logic        enable_q;
    logic [3:0]  sel_q;
    logic        strobe_q;
    pccc_pkg::pccc_state_t state_q;

    logic wr_port, wr_mask, wr_pat, wr_pos, wr_ctl;
    assign wr_port = reg_wr_i && reg_addr_i == pccc_pkg::ADDR_UDP_DEST_PORT;
    assign wr_mask = reg_wr_i && reg_addr_i == pccc_pkg::ADDR_BIT_MASK;
    assign wr_pat  = reg_wr_i && reg_addr_i == pccc_pkg::ADDR_BIT_PATTERN;
    assign wr_pos  = reg_wr_i
                     && reg_addr_i == pccc_pkg::ADDR_POSITION_ENABLE;
    assign wr_ctl  = reg_wr_i && reg_addr_i == pccc_pkg::ADDR_COMMIT_CONTROL;

    // Staged values; reserved bits are simply not stored
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            port_q    <= pccc_pkg::RST_UDP_DEST_PORT;
            mask_q    <= pccc_pkg::RST_BIT_MASK;
            pattern_q <= pccc_pkg::RST_BIT_PATTERN;
            offset_q  <= pccc_pkg::RST_OFFSET;
            enable_q  <= pccc_pkg::RST_ENABLE;
            sel_q     <= pccc_pkg::RST_SELECT;
        end else begin
            if (wr_port) port_q <= reg_wdata_i;
            if (wr_mask) mask_q <= reg_wdata_i;
            if (wr_pat) pattern_q <= reg_wdata_i;
            if (wr_pos) begin
                enable_q <= reg_wdata_i[pccc_pkg::POS_ENABLE];
                offset_q <= reg_wdata_i[pccc_pkg::POS_OFFSET_MSB:0];
            end
            if (wr_ctl) sel_q <= reg_wdata_i[pccc_pkg::POS_SEL_MSB:0];
        end
    end

    // ========================================================
    // Commit sequencer: a strobe write arms, next cycle commits
    pccc_pkg::pccc_state_t state_d;
    logic go_crit, go_hdr;
    assign state_d = (state_q == pccc_pkg::PCCC_IDLE && wr_ctl
                      && reg_wdata_i[pccc_pkg::POS_STROBE])
                     ? pccc_pkg::PCCC_COMMIT : pccc_pkg::PCCC_IDLE;
    assign strobe_q = (state_q == pccc_pkg::PCCC_COMMIT);
    // codes 0-7 only; 8-E commit nothing
    assign go_crit = strobe_q && sel_q <= pccc_pkg::SEL_LAST_CRIT;
    assign go_hdr  = strobe_q && sel_q == pccc_pkg::SEL_HDR_POS;

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) state_q <= pccc_pkg::PCCC_IDLE;
        else state_q <= state_d;
    end

    // Header position: only the offset is taken, enable ignored
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) hdr_pos_q <= pccc_pkg::RST_HDR_POSITION;
        else if (go_hdr) hdr_pos_q <= offset_q;
    end
    assign timing_header_position_o = hdr_pos_q;

    // ========================================================
    // Criterion store
    logic [pccc_pkg::ENTRY_W-1:0] entry_wr, entry_rd;
    assign entry_wr = {enable_q, offset_q, pattern_q, mask_q};

    pccc_crit_mem #(
        .DEPTH (NCRIT),
        .WIDTH (pccc_pkg::ENTRY_W),
        .AW    (3)
    ) u_mem (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .wr_en_i    (go_crit),
        .wr_addr_i  (sel_q[2:0]),
        .wr_data_i  (entry_wr),
        .rd_addr_i  (chk_idx_i),
        .rd_data_o  (entry_rd)
    );

    // ========================================================
    // Register read mux; reserved bits read zero, control bit 7 shows the live strobe
    logic [15:0] rd_pos, rd_ctl;
    assign rd_pos = {enable_q, 7'h00, offset_q};
    assign rd_ctl = {8'h00, strobe_q, 3'h0, sel_q};
    assign reg_rdata_o =
        (reg_addr_i == pccc_pkg::ADDR_UDP_DEST_PORT)   ? port_q    :
        (reg_addr_i == pccc_pkg::ADDR_BIT_MASK)        ? mask_q    :
        (reg_addr_i == pccc_pkg::ADDR_BIT_PATTERN)     ? pattern_q :
        (reg_addr_i == pccc_pkg::ADDR_POSITION_ENABLE) ? rd_pos    :
        (reg_addr_i == pccc_pkg::ADDR_COMMIT_CONTROL)  ? rd_ctl    :
        16'h0000;

    // ========================================================
    // Destination port check
    logic port_cmp_on, port_eq;
    // all ones turns the compare off
    assign port_cmp_on = port_q != pccc_pkg::PORT_MATCH_OFF;
    assign port_eq     = pkt_dest_port_i == port_q;
    assign port_ok_o = !port_cmp_on || port_eq
                       || !((pkt_is_ipv4_i && ipv4_timing_classify_en_i)
                            || (pkt_is_ipv6_i && ipv6_timing_classify_en_i));

    // ========================================================
    // Masked compare, bit 15 being the first bit on the wire
    function automatic logic crit_ok(input logic [15:0] word,
                                     input logic [15:0] pat,
                                     input logic [15:0] msk,
                                     input logic        en);
        crit_ok = !en || (((word ^ pat) & msk) == 16'h0000);
    endfunction : crit_ok

    // Word and flags wait one cycle for the registered memory read
    logic [15:0] word_q;
    logic        vld_q, first_q, last_q, fixed_q, acc_q;
    logic        hit;
    assign hit = crit_ok(word_q, entry_rd[31:16], entry_rd[15:0],
                         entry_rd[40]);

    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            word_q  <= 16'h0000;
            vld_q   <= 1'b0;
            first_q <= 1'b0;
            last_q  <= 1'b0;
            fixed_q <= 1'b0;
        end else begin
            word_q  <= chk_word_i;
            vld_q   <= chk_valid_i;
            first_q <= chk_first_i;
            last_q  <= chk_last_i;
            fixed_q <= fixed_pass_i;
        end
    end

    // Results registered; verdict combines the AND of all hits
    logic cpc_all;
    assign cpc_all = hit && (first_q || acc_q);
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_q         <= 1'b1;
            crit_hit_o    <= 1'b0;
            crit_offset_o <= 8'h00;
            crit_start_o  <= 4'h0;
            pkt_valid_o   <= 1'b0;
            pkt_pass_o    <= 1'b0;
        end else begin
            pkt_valid_o <= vld_q && last_q;
            if (vld_q) begin
                acc_q      <= cpc_all;
                crit_hit_o <= hit;
                crit_offset_o <= entry_rd[39:32];
                crit_start_o  <= start_select_i;
                // AND or OR with fixed classifier
                if (last_q) pkt_pass_o <= combine_or_i
                    ? (cpc_all || fixed_q) : (cpc_all && fixed_q);
            end
        end
    end
endmodule : pccc_top

// File: test/pccc_monitor.sv
// Port-level checker for the criterion configuration block
`timescale 1ns/1ps
module pccc_monitor (
    input wire logic        core_clk_i,  // Core clock
    input wire logic        resetn_i,    // Reset, active low
    input wire logic [5:0]  reg_addr_i,  // Register number
    input wire logic        reg_wr_i,    // Write strobe
    input wire logic [15:0] reg_wdata_i, // Write data
    input wire logic [15:0] reg_rdata_o, // Read data
    input wire logic        chk_valid_i, // Check request
    input wire logic        chk_last_i,  // Last check of packet
    input wire logic        pkt_valid_o, // Verdict pulse
    input wire logic [7:0]  timing_header_position_o // Header position
);
    // ==========================================================
    // One clock domain, so one default clock and disable
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    wire logic mapped = reg_addr_i >= 6'h2A && reg_addr_i <= 6'h2E;
    wire logic at_ctl = reg_addr_i == 6'h2E;
    wire logic strobe_wr = reg_wr_i && at_ctl && reg_wdata_i[7];
    chk_unmapped_zero: assert property (
        !mapped |-> reg_rdata_o == 16'h0000)
        else $error("unmapped register read not zero");
    chk_resv_position: assert property (
        reg_addr_i == 6'h2D |-> reg_rdata_o[14:8] == 7'h00)
        else $error("reserved position bits not zero");
    chk_resv_control: assert property (
        at_ctl |-> {reg_rdata_o[15:8], reg_rdata_o[6:4]} == 11'h000)
        else $error("reserved control bits not zero");
    chk_strobe_clear: assert property (
        at_ctl && reg_rdata_o[7] |=> !at_ctl || !reg_rdata_o[7])
        else $error("strobe stayed set");
    chk_strobe_arm: assert property (
        strobe_wr && !reg_rdata_o[7] |=> !at_ctl || reg_rdata_o[7])
        else $error("strobe write did not arm");
    chk_verdict_late: assert property (
        chk_valid_i && chk_last_i |-> ##2 pkt_valid_o)
        else $error("verdict pulse missing");
    chk_verdict_cause: assert property (
        pkt_valid_o |-> $past(chk_valid_i && chk_last_i, 2))
        else $error("verdict pulse without last check");
    chk_header_commit: assert property (
        $changed(timing_header_position_o) |-> $past(strobe_wr, 2))
        else $error("header position changed without commit");
endmodule : pccc_monitor

// File: test/testbench.sv
// Self-checking bench for the criterion configuration block
`timescale 1ns/1ps
module testbench;
    logic        core_clk_i, resetn_i, reg_wr_i, chk_valid_i, chk_first_i;
    logic        chk_last_i, fixed_pass_i, combine_or_i, pkt_is_ipv4_i;
    logic        pkt_is_ipv6_i, ipv4_timing_classify_en_i, port_ok_o;
    logic        ipv6_timing_classify_en_i, crit_hit_o, pkt_valid_o;
    logic        pkt_pass_o;
    logic [5:0]  reg_addr_i;
    logic [2:0]  chk_idx_i;
    logic [3:0]  start_select_i, crit_start_o;
    logic [7:0]  crit_offset_o, timing_header_position_o;
    logic [15:0] reg_wdata_i, reg_rdata_o, pkt_dest_port_i, chk_word_i;
    logic [5:0]  ra [6] = '{6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E, 6'h30};
    logic [15:0] rv [6] = '{16'h013F, 16'h0, 16'h0, 16'h0, 16'h0, 16'h0};
    int          num_errors, cmp_count;
    pccc_top u_pccc_top (
        .core_clk_i                (core_clk_i),
        .resetn_i                  (resetn_i),
        .reg_addr_i                (reg_addr_i),
        .reg_wr_i                  (reg_wr_i),
        .reg_wdata_i               (reg_wdata_i),
        .reg_rdata_o               (reg_rdata_o),
        .ipv4_timing_classify_en_i (ipv4_timing_classify_en_i),
        .ipv6_timing_classify_en_i (ipv6_timing_classify_en_i),
        .start_select_i            (start_select_i),
        .combine_or_i              (combine_or_i),
        .pkt_is_ipv4_i             (pkt_is_ipv4_i),
        .pkt_is_ipv6_i             (pkt_is_ipv6_i),
        .pkt_dest_port_i           (pkt_dest_port_i),
        .port_ok_o                 (port_ok_o),
        .chk_valid_i               (chk_valid_i),
        .chk_first_i               (chk_first_i),
        .chk_last_i                (chk_last_i),
        .chk_idx_i                 (chk_idx_i),
        .chk_word_i                (chk_word_i),
        .fixed_pass_i              (fixed_pass_i),
        .crit_offset_o             (crit_offset_o),
        .crit_start_o              (crit_start_o),
        .crit_hit_o                (crit_hit_o),
        .pkt_valid_o               (pkt_valid_o),
        .pkt_pass_o                (pkt_pass_o),
        .timing_header_position_o  (timing_header_position_o)
    );
    // ==========================================================
    // Free-running 10 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    // One compare; an unknown matches only an unknown
    task automatic cmp(input string nm, input logic [15:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : cmp
    // Write is one strobed cycle; address is left standing for readback
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        {reg_addr_i, reg_wdata_i, reg_wr_i} <= {a, d, 1'b1};
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [15:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        #1 cmp("rdata", reg_rdata_o, e);
    endtask : rd
    // Stage a set, strobe it and watch the strobe read 1 then 0
    task automatic commit(input logic [3:0] s, input logic [15:0] m, p, o);
        wr(6'h2B, m);
        wr(6'h2C, p);
        wr(6'h2D, o);
        wr(6'h2E, {12'h008, s});
        #1 cmp("strobe", reg_rdata_o, {12'h008, s});
        @(posedge core_clk_i);
        #1 cmp("strobe", reg_rdata_o, {12'h000, s});
    endtask : commit
    // One check request; results land one edge after it is taken,
    // and the verdict pulse stands for that one cycle only
    task automatic chk(input logic [2:0] i, input logic [15:0] w,
                       input logic f, l, fp, eh, input logic [7:0] eo);
        @(posedge core_clk_i);
        {chk_valid_i, chk_idx_i, chk_word_i} <= {1'b1, i, w};
        {chk_first_i, chk_last_i, fixed_pass_i} <= {f, l, fp};
        @(posedge core_clk_i);
        chk_valid_i <= 1'b0;
        @(posedge core_clk_i);
        #1 cmp("hit", crit_hit_o, eh);
        cmp("offset", crit_offset_o, eo);
        cmp("start", crit_start_o, start_select_i);
        cmp("pkt_valid", pkt_valid_o, l);
    endtask : chk
    task automatic finish_test;
        if (num_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // Main sequence
    initial begin
        {resetn_i, reg_wr_i, chk_valid_i, chk_first_i, chk_last_i} = '0;
        {fixed_pass_i, combine_or_i, pkt_is_ipv4_i, pkt_is_ipv6_i} = '0;
        {ipv4_timing_classify_en_i, ipv6_timing_classify_en_i} = 2'b11;
        {reg_addr_i, chk_idx_i, start_select_i} = '0;
        {reg_wdata_i, pkt_dest_port_i, chk_word_i} = '0;
        repeat (4) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        foreach (ra[k]) rd(ra[k], rv[k]);
        wr(6'h2D, 16'hFFFF);
        rd(6'h2D, 16'h80FF);
        wr(6'h2E, 16'hFF7F);
        rd(6'h2E, 16'h000F);
        wr(6'h2A, 16'h1234);
        // IPv4 then IPv6, matching then foreign port
        for (int k = 0; k < 4; k++) begin
            @(posedge core_clk_i);
            {pkt_is_ipv4_i, pkt_is_ipv6_i} <= k[1] ? 2'b01 : 2'b10;
            pkt_dest_port_i <= k[0] ? 16'h1235 : 16'h1234;
            #1 cmp("port_ok", port_ok_o, {15'h0, !k[0]});
        end
        // Foreign IPv6 port passes only while IPv6 classing is off
        @(posedge core_clk_i);
        ipv6_timing_classify_en_i <= 1'b0;
        #1 cmp("port_ok", port_ok_o, 16'h0001);
        @(posedge core_clk_i);
        ipv6_timing_classify_en_i <= 1'b1;
        #1 cmp("port_ok", port_ok_o, 16'h0000);
        wr(6'h2A, 16'hFFFF);
        #1 cmp("port_ok", port_ok_o, 16'h0001);
        start_select_i <= 4'h3;
        // Offsets stay below header position + 32 (header still zero)
        for (int k = 0; k < 8; k++)
            commit(k[3:0], 16'hF00F, {k[3:0], 8'h00, 4'hA},
                   16'h8010 + 16'(k));
        // Middle bits are masked off; bit 0 and bit 15 are compared
        for (int k = 0; k < 8; k++) begin
            chk(k[2:0], {k[3:0], 8'h5C, 4'hA}, 1, 1, 1, 1,
                8'h10 + 8'(k));
            chk(k[2:0], {k[3:0], 8'h5C, 4'hB}, 1, 1, 1, 0,
                8'h10 + 8'(k));
            chk(k[2:0], {1'b1, k[2:0], 8'h00, 4'hA}, 1, 1, 1, 0,
                8'h10 + 8'(k));
        end
        // Every pairing of criterion result, fixed verdict and combine mode
        for (int k = 0; k < 8; k++) begin
            combine_or_i <= k[2];
            chk(3'h0, 16'h000A, 1, 0, 0, 1, 8'h10);
            chk(3'h1, k[0] ? 16'h100A : 16'h100B, 0, 1,
                k[1], k[0], 8'h11);
            cmp("pkt_pass", pkt_pass_o,
                k[2] ? k[0] | k[1] : k[0] & k[1]);
        end
        start_select_i <= 4'h5;
        commit(4'h2, 16'hF00F, 16'h0000, 16'h0012);
        chk(3'h2, 16'hFFFF, 1, 1, 1, 1, 8'h12);
        commit(4'hF, 16'hFFFF, 16'hFFFF, 16'h8021);
        cmp("header", timing_header_position_o, 16'h0021);
        // Code F must leave criterion 7, its low three bits, untouched
        chk(3'h7, 16'h700A, 1, 1, 1, 1, 8'h17);
        // Defined codes only; offset 0x30 stays below 0x21 + 32
        commit(4'h0, 16'h0000, 16'h0000, 16'h0030);
        cmp("header", timing_header_position_o, 16'h0021);
        // Criterion 0 is now disabled, so a foreign word still hits
        chk(3'h0, 16'h000B, 1, 1, 1, 1, 8'h30);
        finish_test();
    end
endmodule : testbench
bind pccc_top pccc_monitor u_pccc_monitor (
    .core_clk_i               (core_clk_i),
    .resetn_i                 (resetn_i),
    .reg_addr_i               (reg_addr_i),
    .reg_wr_i                 (reg_wr_i),
    .reg_wdata_i              (reg_wdata_i),
    .reg_rdata_o              (reg_rdata_o),
    .chk_valid_i              (chk_valid_i),
    .chk_last_i               (chk_last_i),
    .pkt_valid_o              (pkt_valid_o),
    .timing_header_position_o (timing_header_position_o)
);
